// ---- mcsb_addr_status.sv ----
`timescale 1ns/10ps

// Notes on behaviour
// - a selected unit acts on every message carrying no address.
// - an explicit address routes the message, regardless of selection.
// - a select naming another address drops ours; the named unit selects.
// - a select with the broadcast address leaves every unit deselected.
// - own and selected addresses are integers from one to thirty.
// - all commands accept addressing; only one unit answers each message.
// - a query naming one address is answered by that unit always.
// - queries to all or broadcast are answered by the selected unit only.
// - queries listing several addresses are answered by the selected unit, and only if it is in the list.
// - the host-attached unit relays its incoming commands onto RS-485.
// - reading the status byte changes neither byte nor summary flags.
// - error queue flag is set while the error queue holds an entry.
// - questionable flag is set when an event bit meets its enable bit.
// - message ready flag is false while the output queue is empty.
// - standard event flag shows any bit set in standard event register.
// - master summary shows a service reason; service request flag is absent.
// - operation flag is set when any operation status bit is set.
// - the status byte is readable by serial poll and by status query.
// - master summary is OR of status bits 0-5,7 ANDed with enables.
// - status query reply carries master summary in bit six.
// - writing zero to the service request enable clears it entirely.
module mcsb_addr_status (
  // clock and reset
  input  wire logic                         sys_clk,
  input  wire logic                         srst,
  // unit configuration
  input  wire logic [mcsb_pkg::ADDR_W-1:0]  ownAddr,
  input  wire logic                         hostAttached,
  // decoded message in
  input  wire logic                         msgValid,
  output wire logic                         msgReady,
  input  wire mcsb_pkg::mcsb_op_t           msgOp,
  input  wire mcsb_pkg::mcsb_mode_t         msgMode,
  input  wire logic [mcsb_pkg::ADDR_W-1:0]  msgAddr,
  input  wire logic [mcsb_pkg::LIST_W-1:0]  msgAddrList,
  input  wire logic [mcsb_pkg::PARAM_W-1:0] msgParam,
  input  wire logic                         msgFromHost,
  // message outcome
  output wire logic                         execStrobe,
  output wire logic                         answerStrobe,
  output wire logic                         relayStrobe,
  output wire logic                         selected,
  output wire logic [mcsb_pkg::ADDR_W-1:0]  selAddr,
  // query reply
  output wire logic                         replyValid,
  input  wire logic                         replyReady,
  output wire logic [mcsb_pkg::PARAM_W-1:0] replyData,
  // event sources
  input  wire logic [mcsb_pkg::QCNT_W-1:0]  errQueueCount,
  input  wire logic [mcsb_pkg::QCNT_W-1:0]  outQueueCount,
  input  wire logic [mcsb_pkg::QUES_W-1:0]  quesEvent,
  input  wire logic [mcsb_pkg::STD_W-1:0]   stdEvent,
  input  wire logic [mcsb_pkg::OPER_W-1:0]  operStatus,
  // serial poll
  input  wire logic                         pollReq,
  output wire logic                         pollValid,
  output wire logic [mcsb_pkg::BYTE_W-1:0]  pollByte,
  // status view
  output wire logic [mcsb_pkg::BYTE_W-1:0]  statusByte,
  output wire logic [mcsb_pkg::BYTE_W-1:0]  sreValue,
  output wire logic [mcsb_pkg::QUES_W-1:0]  quesEnable
);

  // handler state and latched message
  mcsb_pkg::mcsb_state_t        state_ff;
  mcsb_pkg::mcsb_state_t        nxt_state;
  mcsb_pkg::mcsb_op_t           op_ff;
  mcsb_pkg::mcsb_mode_t         mode_ff;
  logic [mcsb_pkg::ADDR_W-1:0]  addr_ff;
  logic [mcsb_pkg::LIST_W-1:0]  list_ff;
  logic [mcsb_pkg::PARAM_W-1:0] param_ff;
  logic                         fromHost_ff;

  // selection and registers
  logic                         selected_ff;
  logic [mcsb_pkg::ADDR_W-1:0]  selAddr_ff;
  logic [mcsb_pkg::BYTE_W-1:0]  sre_ff;
  logic [mcsb_pkg::QUES_W-1:0]  quesEn_ff;

  // outputs from flip-flops
  logic                         exec_ff;
  logic                         answer_ff;
  logic                         relay_ff;
  logic [mcsb_pkg::PARAM_W-1:0] reply_ff;
  logic                         pollValid_ff;
  logic [mcsb_pkg::BYTE_W-1:0]  pollByte_ff;
  logic [mcsb_pkg::BYTE_W-1:0]  status_ff;

  // decode wires
  wire logic                    ownValid;
  wire logic                    singleHit;
  wire logic                    listHit;
  wire logic                    acceptMsg;
  wire logic                    answerMsg;
  wire logic                    isQuery;
  wire logic                    inExec;
  wire logic                    takeMsg;
  wire logic                    selNamesUs;
  wire logic                    selParamValid;
  wire logic [mcsb_pkg::ADDR_W-1:0] selParam;

  // status summary wires
  wire logic                    errFlag;
  wire logic                    questionable_summary_flag;
  wire logic                    message_ready_flag;
  wire logic                    standard_event_summary_flag;
  wire logic                    operation_summary_flag;
  wire logic                    master_summary_flag;
  wire logic                    service_request_flag;
  wire logic [mcsb_pkg::BYTE_W-1:0] summaryBits;
  wire logic [mcsb_pkg::BYTE_W-1:0] sreMasked;
  wire logic [mcsb_pkg::BYTE_W-1:0] stbWord;
  wire logic [mcsb_pkg::BYTE_W-1:0] pollWord;
  wire logic [mcsb_pkg::PARAM_W-1:0] replyWord;

  // ---------------- addressing decode ----------------
  assign ownValid  = (ownAddr >= mcsb_pkg::ADDR_MIN) &&
                     (ownAddr <= mcsb_pkg::ADDR_MAX);
  assign singleHit = ownValid && (addr_ff == ownAddr);
  assign listHit   = ownValid && list_ff[ownAddr];

  // whether this unit acts on the latched message
  assign acceptMsg =
    (mode_ff == mcsb_pkg::MODE_NONE)   ? selected_ff :
    (mode_ff == mcsb_pkg::MODE_SINGLE) ? singleHit   :
    (mode_ff == mcsb_pkg::MODE_ALL)    ? 1'b1        :
                                         listHit;

  // only one unit on the chain may answer a message
  assign answerMsg =
    (mode_ff == mcsb_pkg::MODE_NONE)   ? selected_ff :
    (mode_ff == mcsb_pkg::MODE_SINGLE) ? singleHit   :
    (mode_ff == mcsb_pkg::MODE_ALL)    ? selected_ff :
                                         selected_ff && listHit;

  assign isQuery = (op_ff == mcsb_pkg::OP_STB_QRY) ||
                   (op_ff == mcsb_pkg::OP_SRE_QRY) ||
                   (op_ff == mcsb_pkg::OP_GEN_QRY);

  // selection commands are seen by every unit on the chain
  assign selParam      = param_ff[mcsb_pkg::ADDR_W-1:0];
  assign selParamValid = (selParam >= mcsb_pkg::ADDR_MIN) &&
                         (selParam <= mcsb_pkg::ADDR_MAX) &&
                         (param_ff[mcsb_pkg::PARAM_W-1:mcsb_pkg::ADDR_W] ==
                          '0);
  assign selNamesUs    = selParamValid && ownValid &&
                         (selParam == ownAddr);

  // ---------------- handshake and state ----------------
  assign msgReady = (state_ff == mcsb_pkg::ST_IDLE);
  assign takeMsg  = msgValid && msgReady;
  assign inExec   = (state_ff == mcsb_pkg::ST_EXEC);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      mcsb_pkg::ST_IDLE: begin
        if (msgValid) begin
          nxt_state = mcsb_pkg::ST_EXEC;
        end
      end
      mcsb_pkg::ST_EXEC: begin
        if (isQuery && answerMsg) begin
          nxt_state = mcsb_pkg::ST_REPLY;
        end else begin
          nxt_state = mcsb_pkg::ST_IDLE;
        end
      end
      mcsb_pkg::ST_REPLY: begin
        if (replyReady) begin
          nxt_state = mcsb_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = mcsb_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_ff <= mcsb_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latch the message when it is taken
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      op_ff       <= mcsb_pkg::OP_GENERIC;
      mode_ff     <= mcsb_pkg::MODE_NONE;
      addr_ff     <= mcsb_pkg::ADDR_BCAST;
      list_ff     <= '0;
      param_ff    <= mcsb_pkg::PARAM_ZERO;
      fromHost_ff <= 1'b0;
    end else if (takeMsg) begin
      op_ff       <= msgOp;
      mode_ff     <= msgMode;
      addr_ff     <= msgAddr;
      list_ff     <= msgAddrList;
      param_ff    <= msgParam;
      fromHost_ff <= msgFromHost;
    end
  end

  // ---------------- selection ----------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      selected_ff <= 1'b0;
      selAddr_ff  <= mcsb_pkg::ADDR_BCAST;
    end else if (inExec && (op_ff == mcsb_pkg::OP_SELECT)) begin
      selected_ff <= selNamesUs;
      selAddr_ff  <= selParamValid ? selParam
                                   : mcsb_pkg::ADDR_BCAST;
    end
  end

  // ---------------- enable registers ----------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sre_ff <= mcsb_pkg::SRE_RST;
    end else if (inExec && acceptMsg &&
                 (op_ff == mcsb_pkg::OP_SRE_WR)) begin
      sre_ff <= param_ff[mcsb_pkg::BYTE_W-1:0] &
                mcsb_pkg::SRE_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      quesEn_ff <= mcsb_pkg::QEN_RST;
    end else if (inExec && acceptMsg &&
                 (op_ff == mcsb_pkg::OP_QEN_WR)) begin
      quesEn_ff <= param_ff;
    end
  end

  // ---------------- message outcome strobes ----------------
  // a discarded message leaves exec and answer strobes low and no enable register touched; a select still updates selection; relay still follows fromHost_ff
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      exec_ff   <= 1'b0;
      answer_ff <= 1'b0;
      relay_ff  <= 1'b0;
    end else begin
      exec_ff   <= inExec && acceptMsg;
      answer_ff <= inExec && acceptMsg && isQuery && answerMsg;
      relay_ff  <= inExec && hostAttached && fromHost_ff;
    end
  end

  // ---------------- status summary ----------------
  assign errFlag                     = (errQueueCount !=
                                        mcsb_pkg::QCNT_ZERO);
  assign message_ready_flag          = (outQueueCount !=
                                        mcsb_pkg::QCNT_ZERO);
  assign standard_event_summary_flag = |stdEvent;
  assign operation_summary_flag      = |operStatus;
  assign service_request_flag        = 1'b0;

  mcsb_mask_or #(
    .W (mcsb_pkg::QUES_W)
  ) u_ques_or (
    .evBits (quesEvent),
    .enBits (quesEn_ff),
    .anyHit (questionable_summary_flag)
  );

  assign summaryBits = {operation_summary_flag,
                        1'b0,
                        standard_event_summary_flag,
                        message_ready_flag,
                        questionable_summary_flag,
                        errFlag,
                        2'b00};

  // bit 6 of the summary is excluded by the masked enable
  assign sreMasked = sre_ff & mcsb_pkg::SRE_MASK;

  mcsb_mask_or #(
    .W (mcsb_pkg::BYTE_W)
  ) u_mss_or (
    .evBits (summaryBits),
    .enBits (sreMasked),
    .anyHit (master_summary_flag)
  );

  // query word carries master summary, poll word the service request bit
  assign stbWord  = summaryBits |
                    ({7'h00, master_summary_flag} <<
                     mcsb_pkg::SB_MSS);
  assign pollWord = summaryBits |
                    ({7'h00, service_request_flag} <<
                     mcsb_pkg::SB_MSS);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      status_ff <= mcsb_pkg::BYTE_ZERO;
    end else begin
      status_ff <= stbWord;
    end
  end

  // ---------------- query reply ----------------
  assign replyWord =
    (op_ff == mcsb_pkg::OP_STB_QRY) ? {8'h00, stbWord} :
    (op_ff == mcsb_pkg::OP_SRE_QRY) ? {8'h00, sre_ff}  :
                                      mcsb_pkg::PARAM_ZERO;

  // reading the status byte is side-effect free
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reply_ff <= mcsb_pkg::PARAM_ZERO;
    end else if (inExec && isQuery && answerMsg) begin
      reply_ff <= replyWord;
    end
  end

  // ---------------- serial poll ----------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pollValid_ff <= 1'b0;
      pollByte_ff  <= mcsb_pkg::BYTE_ZERO;
    end else begin
      pollValid_ff <= pollReq;
      if (pollReq) begin
        pollByte_ff <= pollWord;
      end
    end
  end

  // ---------------- output wiring ----------------
  assign execStrobe   = exec_ff;
  assign answerStrobe = answer_ff;
  assign relayStrobe  = relay_ff;
  assign selected     = selected_ff;
  assign selAddr      = selAddr_ff;
  assign replyValid   = (state_ff == mcsb_pkg::ST_REPLY);
  assign replyData    = reply_ff;
  assign pollValid    = pollValid_ff;
  assign pollByte     = pollByte_ff;
  assign statusByte   = status_ff;
  assign sreValue     = sre_ff;
  assign quesEnable   = quesEn_ff;

endmodule : mcsb_addr_status

// ---- mcsb_host_model.sv ----
`timescale 1ns/10ps

// controller side of the reply channel, optionally slow to take replies
module mcsb_host_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // reply channel
  input  wire logic        replyValid,
  input  wire logic [15:0] replyData,
  output logic             replyReady,
  // stall setting and capture
  input  wire logic [3:0]  stall,
  output logic [15:0]      gotData,
  output logic [7:0]       gotCount
);
  logic [3:0] waitCnt;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      replyReady <= 1'b0;
      waitCnt    <= 4'h0;
      gotData    <= 16'h0000;
      gotCount   <= 8'h00;
    end else if (replyValid && replyReady) begin
      gotData    <= replyData;
      gotCount   <= gotCount + 8'h01;
      replyReady <= 1'b0;
      waitCnt    <= 4'h0;
    end else if (replyValid && waitCnt >= stall) begin
      replyReady <= 1'b1;
    end else if (replyValid) begin
      waitCnt    <= waitCnt + 4'h1;
    end
  end
endmodule : mcsb_host_model

// ---- mcsb_mask_or.sv ----
`timescale 1ns/10ps

// flags when any event bit is set together with its enable bit
module mcsb_mask_or #(
  parameter int W = 8
) (
  // event and enable bits
  input  wire logic [W-1:0] evBits,
  input  wire logic [W-1:0] enBits,
  // summary
  output wire logic         anyHit
);

  wire logic [W-1:0] hitBits;

  assign hitBits = evBits & enBits;
  assign anyHit  = |hitBits;

endmodule : mcsb_mask_or

// ---- mcsb_monitor.sv ----
`timescale 1ns/10ps

module mcsb_monitor (
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        srst,
  // configuration and message
  input wire logic [4:0]                  ownAddr,
  input wire logic                        hostAttached,
  input wire logic                        msgValid,
  input wire logic                        msgReady,
  input wire mcsb_pkg::mcsb_op_t          msgOp,
  input wire mcsb_pkg::mcsb_mode_t        msgMode,
  input wire logic [4:0]                  msgAddr,
  input wire logic [31:0]                 msgAddrList,
  input wire logic [15:0]                 msgParam,
  input wire logic                        msgFromHost,
  // outcome
  input wire logic                        execStrobe,
  input wire logic                        answerStrobe,
  input wire logic                        relayStrobe,
  input wire logic                        selected,
  input wire logic                        replyValid,
  // status
  input wire logic [7:0]                  errQueueCount,
  input wire logic                        pollReq,
  input wire logic                        pollValid,
  input wire logic [7:0]                  pollByte,
  input wire logic [7:0]                  statusByte,
  input wire logic [7:0]                  sreValue
);
  wire logic take     = msgValid && msgReady;
  wire logic isQry    = (msgOp == mcsb_pkg::OP_STB_QRY) ||
                        (msgOp == mcsb_pkg::OP_SRE_QRY) ||
                        (msgOp == mcsb_pkg::OP_GEN_QRY);
  wire logic notSel   = msgOp != mcsb_pkg::OP_SELECT;
  wire logic multiHit = selected && msgAddrList[ownAddr];

  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  busy_hold_a: assert property (take |=> !msgReady)
    else $error("message taken while busy");
  single_answer_a: assert property (take && isQry && msgAddr == ownAddr
    && msgMode == mcsb_pkg::MODE_SINGLE |-> ##2 answerStrobe && replyValid)
    else $error("own single query not answered");
  all_answer_a: assert property (take && isQry
    && msgMode == mcsb_pkg::MODE_ALL |-> ##2 answerStrobe == $past(selected, 2))
    else $error("all query answer wrong");
  multi_answer_a: assert property (take && isQry
    && msgMode == mcsb_pkg::MODE_MULTI |-> ##2 answerStrobe == $past(multiHit, 2))
    else $error("list query answer wrong");
  relay_out_a: assert property (take && hostAttached && msgFromHost
    |-> ##2 relayStrobe) else $error("relay missing");
  bcast_desel_a: assert property (take && !notSel
    && msgParam == 16'h0000 |-> ##2 !selected) else $error("still selected");
  unaddr_drop_a: assert property (take && notSel && !selected
    && msgMode == mcsb_pkg::MODE_NONE |-> ##2 !execStrobe && !answerStrobe)
    else $error("unselected unit acted");
  sel_exec_a: assert property (take && notSel && selected
    && msgMode == mcsb_pkg::MODE_NONE |-> ##2 execStrobe)
    else $error("selected unit ignored message");
  err_flag_a: assert property (!$past(srst) |-> statusByte[2]
    == ($past(errQueueCount) != 8'h00)) else $error("error flag wrong");
  mss_flag_a: assert property (!$past(srst) |-> statusByte[6]
    == |(statusByte & $past(sreValue) & 8'hbf)) else $error("summary wrong");
  poll_ans_a: assert property (pollReq |=> pollValid && !pollByte[6])
    else $error("poll answer wrong");
endmodule : mcsb_monitor

bind mcsb_addr_status mcsb_monitor mcsb_monitor_i (.sys_clk, .srst,
  .ownAddr, .hostAttached, .msgValid, .msgReady, .msgOp, .msgMode, .msgAddr,
  .msgAddrList, .msgParam, .msgFromHost, .execStrobe, .answerStrobe,
  .relayStrobe, .selected, .replyValid, .errQueueCount, .pollReq,
  .pollValid, .pollByte, .statusByte, .sreValue);

// ---- mcsb_pkg.sv ----
package mcsb_pkg;

  // multichannel addressing
  localparam int          ADDR_W     = 5;
  localparam logic [4:0]  ADDR_BCAST = 5'h00;
  localparam logic [4:0]  ADDR_MIN   = 5'h01;
  localparam logic [4:0]  ADDR_MAX   = 5'h1e;
  localparam int          LIST_W     = 32;

  // message parameter and event register widths
  localparam int          PARAM_W    = 16;
  localparam int          QUES_W     = 16;
  localparam int          OPER_W     = 16;
  localparam int          STD_W      = 8;
  localparam int          QCNT_W     = 8;
  localparam int          BYTE_W     = 8;

  // status summary byte bit positions
  localparam int          SB_ERR     = 2;
  localparam int          SB_QUES    = 3;
  localparam int          SB_MAV     = 4;
  localparam int          SB_ESB     = 5;
  localparam int          SB_MSS     = 6;
  localparam int          SB_OSR     = 7;

  // reset values
  localparam logic [7:0]  SRE_RST    = 8'h00;
  localparam logic [15:0] QEN_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_ZERO  = 8'h00;
  localparam logic [15:0] PARAM_ZERO = 16'h0000;
  localparam logic [7:0]  QCNT_ZERO  = 8'h00;

  // bit 6 of the enable register never takes part in the summary
  localparam logic [7:0]  SRE_MASK   = 8'hbf;

  // how a message is addressed
  typedef enum logic [1:0] {
    MODE_NONE   = 2'h0,
    MODE_SINGLE = 2'h1,
    MODE_ALL    = 2'h2,
    MODE_MULTI  = 2'h3
  } mcsb_mode_t;

  // decoded command kinds
  typedef enum logic [2:0] {
    OP_GENERIC  = 3'h0,
    OP_SELECT   = 3'h1,
    OP_STB_QRY  = 3'h2,
    OP_SRE_WR   = 3'h3,
    OP_SRE_QRY  = 3'h4,
    OP_QEN_WR   = 3'h5,
    OP_GEN_QRY  = 3'h6
  } mcsb_op_t;

  // message handler states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_EXEC  = 3'b010,
    ST_REPLY = 3'b100
  } mcsb_state_t;

endpackage : mcsb_pkg

// ---- testbench.sv ----
`timescale 1ns/10ps

module testbench;
  localparam mcsb_pkg::mcsb_op_t   GEN = mcsb_pkg::OP_GENERIC;
  localparam mcsb_pkg::mcsb_op_t   SEL = mcsb_pkg::OP_SELECT;
  localparam mcsb_pkg::mcsb_op_t   GQ  = mcsb_pkg::OP_GEN_QRY;
  localparam mcsb_pkg::mcsb_mode_t NON = mcsb_pkg::MODE_NONE;
  localparam mcsb_pkg::mcsb_mode_t SGL = mcsb_pkg::MODE_SINGLE;
  localparam mcsb_pkg::mcsb_mode_t ALL = mcsb_pkg::MODE_ALL;
  localparam mcsb_pkg::mcsb_mode_t MUL = mcsb_pkg::MODE_MULTI;
  logic                 sys_clk = 1'b0, srst = 1'b1, msgValid = 1'b0;
  logic                 hostAttached = 1'b0, msgFromHost = 1'b0;
  logic                 pollReq = 1'b0, ex, an, rl;
  logic [4:0]           ownAddr = 5'h05, msgAddr = 5'h00, selAddr;
  mcsb_pkg::mcsb_op_t   msgOp = GEN;
  mcsb_pkg::mcsb_mode_t msgMode = NON;
  logic [31:0]          msgAddrList = 32'h0;
  logic [15:0]          msgParam = 16'h0, quesEvent = 16'h0;
  logic [15:0]          operStatus = 16'h0, replyData, gotData, quesEnable;
  logic [7:0]           errQueueCount = 8'h0, outQueueCount = 8'h0;
  logic [7:0]           stdEvent = 8'h0, pollByte, statusByte, sreValue;
  logic [7:0]           gotCount;
  logic [3:0]           stall = 4'h0;
  logic                 msgReady, execStrobe, answerStrobe, relayStrobe;
  logic                 selected, replyValid, replyReady, pollValid;
  int                   fails = 0, cmp_count = 0, cyc = 0;

  mcsb_addr_status mcsb_addr_status_i (.sys_clk, .srst, .ownAddr,
    .hostAttached, .msgValid, .msgReady, .msgOp, .msgMode, .msgAddr,
    .msgAddrList, .msgParam, .msgFromHost, .execStrobe, .answerStrobe,
    .relayStrobe, .selected, .selAddr, .replyValid, .replyReady,
    .replyData, .errQueueCount, .outQueueCount, .quesEvent, .stdEvent,
    .operStatus, .pollReq, .pollValid, .pollByte, .statusByte, .sreValue,
    .quesEnable);
  mcsb_host_model mcsb_host_model_i (.sys_clk, .srst, .replyValid,
    .replyData, .replyReady, .stall, .gotData, .gotCount);

  always #12.5 sys_clk = ~sys_clk;

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fails++;
      $display("timeout after %0d cycles", cyc);
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // offer one message, then sample the strobes one cycle after the take
  task automatic send(input mcsb_pkg::mcsb_op_t op,
      input mcsb_pkg::mcsb_mode_t md, input logic [4:0] a,
      input logic [31:0] l, input logic [15:0] p);
    msgOp = op;
    msgMode = md;
    msgAddr = a;
    msgAddrList = l;
    msgParam = p;
    msgValid = 1'b1;
    @(posedge sys_clk) #2;
    msgValid = 1'b0;
    @(posedge sys_clk) #2;
    ex = execStrobe;
    an = answerStrobe;
    rl = relayStrobe;
    for (int i = 0; i < 40 && !msgReady; i++) @(posedge sys_clk) #2;
  endtask : send

  task automatic qry(input mcsb_pkg::mcsb_op_t op,
      input mcsb_pkg::mcsb_mode_t md, input logic [4:0] a,
      input logic [31:0] l, input logic e, input logic [15:0] d);
    logic [7:0] n;
    n = gotCount;
    send(op, md, a, l, 16'h0000);
    chk("answer", e, an);
    chk("replies", n + e, gotCount);
    if (e) chk("reply", d, gotData);
  endtask : qry

  task automatic stat(input logic [7:0] e, o, s, input logic [15:0] q, p,
      input logic [7:0] x);
    errQueueCount = e;
    outQueueCount = o;
    stdEvent = s;
    quesEvent = q;
    operStatus = p;
    @(posedge sys_clk) #2;
    chk("status", x, statusByte);
  endtask : stat

  initial begin
    repeat (3) @(posedge sys_clk);
    #2 srst = 1'b0;
    chk("selected", 1'b0, selected);
    chk("sre", 8'h00, sreValue);
    chk("qen", 16'h0000, quesEnable);
    $display("test reset done");
    send(GEN, NON, 5'h00, 32'h0, 16'h0000); chk("exec", 1'b0, ex);
    send(SEL, NON, 5'h00, 32'h0, 16'h0005); chk("sel", 1'b1, selected);
    chk("selAddr", 5'h05, selAddr);
    send(GEN, NON, 5'h00, 32'h0, 16'h0000); chk("exec", 1'b1, ex);
    send(GEN, SGL, 5'h06, 32'h0, 16'h0000); chk("exec", 1'b0, ex);
    send(SEL, NON, 5'h00, 32'h0, 16'h0007); chk("sel", 1'b0, selected);
    send(SEL, NON, 5'h00, 32'h0, 16'h0005);
    send(SEL, ALL, 5'h00, 32'h0, 16'h0000); chk("sel", 1'b0, selected);
    send(SEL, NON, 5'h00, 32'h0, 16'h0025); chk("sel", 1'b0, selected);
    $display("test selection done");
    qry(GQ, SGL, 5'h05, 32'h0, 1'b1, 16'h0000);
    qry(GQ, SGL, 5'h06, 32'h0, 1'b0, 16'h0000);
    qry(GQ, ALL, 5'h00, 32'h0, 1'b0, 16'h0000);
    qry(GQ, MUL, 5'h00, 32'h20, 1'b0, 16'h0000);
    send(SEL, NON, 5'h00, 32'h0, 16'h0005);
    stall = 4'h3;
    qry(GQ, ALL, 5'h00, 32'h0, 1'b1, 16'h0000);
    qry(GQ, MUL, 5'h00, 32'h20, 1'b1, 16'h0000);
    qry(GQ, MUL, 5'h00, 32'h40, 1'b0, 16'h0000);
    stall = 4'h0;
    qry(GQ, NON, 5'h00, 32'h0, 1'b1, 16'h0000);
    $display("test responses done");
    send(mcsb_pkg::OP_QEN_WR, SGL, 5'h05, 32'h0, 16'h0001);
    stat(8'h01, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h04);
    stat(8'h00, 8'h00, 8'h00, 16'h0002, 16'h0000, 8'h00);
    stat(8'h00, 8'h00, 8'h00, 16'h0001, 16'h0000, 8'h08);
    stat(8'h00, 8'h03, 8'h00, 16'h0000, 16'h0000, 8'h10);
    stat(8'h00, 8'h00, 8'h80, 16'h0000, 16'h0000, 8'h20);
    stat(8'h00, 8'h00, 8'h00, 16'h0000, 16'h8000, 8'h80);
    stat(8'h01, 8'h01, 8'h01, 16'h0001, 16'h0001, 8'hbc);
    send(mcsb_pkg::OP_SRE_WR, SGL, 5'h05, 32'h0, 16'h00ff);
    chk("sre", 8'hbf, sreValue);
    stat(8'h01, 8'h01, 8'h01, 16'h0001, 16'h0001, 8'hfc);
    qry(mcsb_pkg::OP_STB_QRY, SGL, 5'h05, 32'h0, 1'b1, 16'h00fc);
    chk("status", 8'hfc, statusByte);
    qry(mcsb_pkg::OP_SRE_QRY, SGL, 5'h05, 32'h0, 1'b1, 16'h00bf);
    pollReq = 1'b1;
    @(posedge sys_clk) #2;
    pollReq = 1'b0;
    chk("pollValid", 1'b1, pollValid);
    chk("pollByte", 8'hbc, pollByte);
    stat(8'h01, 8'h00, 8'h00, 16'h0000, 16'h0000, 8'h44);
    send(mcsb_pkg::OP_SRE_WR, SGL, 5'h05, 32'h0, 16'h0000);
    chk("sre", 8'h00, sreValue);
    stat(8'h01, 8'h01, 8'h01, 16'h0001, 16'h0001, 8'hbc);
    $display("test status done");
    hostAttached = 1'b1;
    msgFromHost = 1'b1;
    send(GEN, SGL, 5'h09, 32'h0, 16'h0000); chk("relay", 1'b1, rl);
    chk("exec", 1'b0, ex);
    msgFromHost = 1'b0;
    send(GEN, SGL, 5'h09, 32'h0, 16'h0000); chk("relay", 1'b0, rl);
    $display("test relay done");
    final_report();
  end
endmodule : testbench
